// ### rtl/uscr_pkg.sv
// Shared constants and types of the charger status register bank.
package uscr_pkg;

	// ==================================================================
	// Register indices, as carried in the register-address byte.
	localparam logic [7:0] USCR_IDX_SETUP1 = 8'h00;
	localparam logic [7:0] USCR_IDX_SETUP2 = 8'h01;
	localparam logic [7:0] USCR_IDX_SETUP3 = 8'h02;
	localparam logic [7:0] USCR_IDX_SETUP4 = 8'h03;
	localparam logic [7:0] USCR_IDX_IRQ_EN_LOWER = 8'h04;
	localparam logic [7:0] USCR_IDX_IRQ_EN_UPPER = 8'h05;
	localparam logic [7:0] USCR_IDX_LIVE_STATUS = 8'h06;
	localparam logic [7:0] USCR_IDX_EVENT_MAIN = 8'h07;
	localparam logic [7:0] USCR_IDX_EVENT_AUX = 8'h08;
	localparam logic [7:0] USCR_IDX_BUS_VOLTAGE = 8'h09;
	localparam logic [7:0] USCR_IDX_BUS_CURRENT = 8'h0a;
	localparam int USCR_REG_COUNT = 11;

	// ==================================================================
	// Field positions.
	localparam int USCR_STAT_ATTACH_BIT = 7;
	localparam int USCR_STAT_CONFIGURED_BIT = 6;
	localparam int USCR_EVM_ATTACH_BIT = 7;
	localparam int USCR_EVA_CFG_REQ_BIT = 2;
	localparam int USCR_EVA_CONV_DONE_BIT = 1;
	localparam int USCR_EVA_INPUT_OVERVOLTAGE_FLAG_BIT = 0;
	localparam int USCR_UPPER_INPUT_OVERVOLTAGE_FLAG_BIT = 0;
	localparam int USCR_S4_LATCH_SEL_BIT = 7;
	localparam int USCR_S4_CONV_START_BIT = 6;
	localparam int USCR_S4_CONV_IRQ_BIT = 5;
	localparam int USCR_S1_VOUT_LSB = 0;

	// ==================================================================
	// Values after reset and implemented-bit masks.
	localparam logic [7:0] USCR_RST_SETUP1 = 8'h00;
	localparam logic [7:0] USCR_RST_SETUP2 = 8'h00;
	localparam logic [7:0] USCR_RST_SETUP3 = 8'h0c;
	localparam logic [7:0] USCR_RST_SETUP4 = 8'h17;
	localparam logic [7:0] USCR_RST_ZERO = 8'h00;
	localparam logic [7:0] USCR_MASK_UPPER = 8'h01;
	localparam logic [7:0] USCR_MASK_EVENT_AUX = 8'h07;
	localparam logic [6:0] USCR_ADDR_BASE = 7'h30;
	localparam logic [3:0] USCR_BITS_PER_BYTE = 4'h8;

	// ==================================================================
	// Types.
	typedef enum logic [4:0] {
		USCR_ST_IDLE = 5'b00001,
		USCR_ST_RECV = 5'b00010,
		USCR_ST_ACK = 5'b00100,
		USCR_ST_SEND = 5'b01000,
		USCR_ST_HACK = 5'b10000
	} uscr_state_e;

	typedef enum logic [1:0] {
		USCR_KIND_ADDR = 2'h0,
		USCR_KIND_REG = 2'h1,
		USCR_KIND_DATA = 2'h2
	} uscr_kind_e;

	// Conditions seen on the serial pins, one-cycle pulses except sda.
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} uscr_line_s;

	// Conversion results handed in by the converter.
	typedef struct packed {
		logic done;
		logic [7:0] voltage;
		logic [7:0] current;
	} uscr_adc_s;

endpackage : uscr_pkg

// ### rtl/uscr_line_sense.sv
// Serial pin synchroniser and bus-condition detector.
`timescale 1ns/1ps
`default_nettype none
module uscr_line_sense (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output uscr_pkg::uscr_line_s line_o
);
	import uscr_pkg::*;

	// ==================================================================
	// Two-stage synchronisers; only the second stage and later are used.
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_prev_r;
	logic sda_prev_r;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_prev_r <= scl_sync_r[1];
			sda_prev_r <= sda_sync_r[1];
		end
	end

	// ==================================================================
	// A data edge while the clock stays high is a start or a stop.
	always_comb begin
		line_o.start = scl_sync_r[1] && scl_prev_r && sda_prev_r && !sda_sync_r[1];
		line_o.stop = scl_sync_r[1] && scl_prev_r && !sda_prev_r && sda_sync_r[1];
		line_o.scl_rise = scl_sync_r[1] && !scl_prev_r;
		line_o.scl_fall = !scl_sync_r[1] && scl_prev_r;
		line_o.sda = sda_sync_r[1];
	end

endmodule // uscr_line_sense
`default_nettype wire

// ### rtl/uscr_status_regs.sv
// Status, event and measurement registers of the charger, reached over a two-wire target port.
//
// Summary of operation
// - Upper enable bit 0 gates input overvoltage.
// - Status bit 7 follows attach detection.
// - Converter held off until configured flag set.
// - Standard variants preset configured flag to one.
// - Eight main event flags, cleared on read.
// - Special variants request configuration after power-on.
// - Standard variants never raise configuration request.
// - Conversion stores results, sets done flag.
// - Aux bit 0 latches input overvoltage.
// - Voltage result register, eight bits, resets zero.
// - Current result register, eight bits, resets zero.
// - Target address taken from strap pin.
// - Address byte: seven bits then direction.
// - Acknowledge by pulling data low, ninth clock.
// - Read: register byte, restart, data bytes while the host acknowledges.
// - Interrupt output for enabled events.
// - Eleven eight-bit registers exposed.
// - Stand-alone variants preload setup from straps.
// - Latch select: auto-clear or hold until read.
// - Conversion start bit cleared when conversion completes.
// - Lower enables match main event bit positions.
`timescale 1ns/1ps
`default_nettype none
module uscr_status_regs #(
	parameter bit SPECIAL_ORDER = 1'b0,
	parameter bit STAND_ALONE = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic first_strap_pin_i,
	input wire logic [7:0] strap_setup1_i,
	input wire logic [7:0] strap_setup4_i,
	input wire logic attach_i,
	input wire logic [6:0] fault_i,
	input wire logic input_overvoltage_i,
	input wire uscr_pkg::uscr_adc_s adc_i,
	output logic adc_start_o,
	output logic [2:0] output_voltage_mode_o,
	output logic [7:0] setup2_o,
	output logic [7:0] setup3_o,
	output logic dcdc_enable_o,
	output logic irq_o
);
	import uscr_pkg::*;

	// ==================================================================
	// Declarations.
	uscr_line_s line;
	uscr_state_e state_r;
	uscr_kind_e kind_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic host_ack_r;
	logic [6:0] own_addr_r;
	logic strap_taken_r;
	logic [7:0] setup1_r;
	logic [7:0] setup2_r;
	logic [7:0] setup3_r;
	logic [7:0] setup4_r;
	logic [7:0] irq_en_lower_r;
	logic [7:0] irq_en_upper_r;
	logic configured_r;
	logic [7:0] event_main_r;
	logic [7:0] event_aux_r;
	logic [7:0] bus_voltage_r;
	logic [7:0] bus_current_r;
	logic attach_prev_r;
	logic cfg_req_armed_r;
	logic wr_pulse;
	logic rd_pulse;
	logic [7:0] rd_idx;
	logic [7:0] main_src;
	logic latch_sel;

	// Register read decode, used for the first byte and every later one.
	function automatic logic [7:0] reg_read(input logic [7:0] idx);
		case (idx)
			USCR_IDX_SETUP1: reg_read = setup1_r;
			USCR_IDX_SETUP2: reg_read = setup2_r;
			USCR_IDX_SETUP3: reg_read = setup3_r;
			USCR_IDX_SETUP4: reg_read = setup4_r;
			USCR_IDX_IRQ_EN_LOWER: reg_read = irq_en_lower_r;
			USCR_IDX_IRQ_EN_UPPER: reg_read = irq_en_upper_r & USCR_MASK_UPPER;
			USCR_IDX_LIVE_STATUS: reg_read = {attach_i, configured_r, 6'h00};
			USCR_IDX_EVENT_MAIN: reg_read = event_main_r;
			USCR_IDX_EVENT_AUX: reg_read = event_aux_r & USCR_MASK_EVENT_AUX;
			USCR_IDX_BUS_VOLTAGE: reg_read = bus_voltage_r;
			USCR_IDX_BUS_CURRENT: reg_read = bus_current_r;
			default: reg_read = 8'h00;
		endcase
	endfunction

	// ==================================================================
	// Pin conditioning.
	uscr_line_sense u_line (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.line_o(line)
	);

	// ==================================================================
	// Address strap, caught once after reset release.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			own_addr_r <= USCR_ADDR_BASE;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r) begin
			own_addr_r <= {USCR_ADDR_BASE[6:1], first_strap_pin_i};
			strap_taken_r <= 1'b1;
		end
	end

	// ==================================================================
	// Serial target state machine.
	// Data is sampled on clock rise and changed only on clock fall, so the
	// acknowledge stays stable through the whole high period.
	assign rd_idx = (state_r == USCR_ST_ACK) ? ptr_r : ptr_r + 8'h01;
	assign rd_pulse = line.scl_fall && !line.start && !line.stop &&
		(((state_r == USCR_ST_ACK) && (kind_r == USCR_KIND_ADDR) && rw_r) ||
		((state_r == USCR_ST_HACK) && host_ack_r));
	assign wr_pulse = line.scl_fall && (state_r == USCR_ST_RECV) && (kind_r == USCR_KIND_DATA) &&
		(bit_cnt_r == USCR_BITS_PER_BYTE);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= USCR_ST_IDLE;
			kind_r <= USCR_KIND_ADDR;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			host_ack_r <= 1'b0;
		end else if (line.start) begin
			state_r <= USCR_ST_RECV;
			kind_r <= USCR_KIND_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (line.stop) begin
			state_r <= USCR_ST_IDLE;
		end else begin
			case (state_r)
				USCR_ST_IDLE: begin
					bit_cnt_r <= 4'h0;
				end
				USCR_ST_RECV: begin
					if (line.scl_rise) begin
						shift_r <= {shift_r[6:0], line.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (line.scl_fall && bit_cnt_r == USCR_BITS_PER_BYTE) begin
						bit_cnt_r <= 4'h0;
						state_r <= USCR_ST_ACK;
						case (kind_r)
							USCR_KIND_ADDR: begin
								rw_r <= shift_r[0];
								if (shift_r[7:1] != own_addr_r) begin
									state_r <= USCR_ST_IDLE;
								end
							end
							USCR_KIND_REG: begin
								ptr_r <= shift_r;
							end
							default: begin
							end
						endcase
					end
				end
				USCR_ST_ACK: begin
					if (line.scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (kind_r == USCR_KIND_ADDR && rw_r) begin
							tx_r <= reg_read(ptr_r);
							state_r <= USCR_ST_SEND;
						end else begin
							state_r <= USCR_ST_RECV;
							if (kind_r == USCR_KIND_DATA) begin
								ptr_r <= ptr_r + 8'h01;
							end else begin
								kind_r <= (kind_r == USCR_KIND_ADDR) ? USCR_KIND_REG : USCR_KIND_DATA;
							end
						end
					end
				end
				USCR_ST_SEND: begin
					if (line.scl_fall) begin
						tx_r <= {tx_r[6:0], 1'b0};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r == USCR_BITS_PER_BYTE - 4'h1) begin
							state_r <= USCR_ST_HACK;
						end
					end
				end
				USCR_ST_HACK: begin
					if (line.scl_rise) begin
						host_ack_r <= !line.sda;
					end else if (line.scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (host_ack_r) begin
							ptr_r <= rd_idx;
							tx_r <= reg_read(rd_idx);
							state_r <= USCR_ST_SEND;
						end else begin
							state_r <= USCR_ST_IDLE;
						end
					end
				end
				default: begin
					state_r <= USCR_ST_IDLE;
				end
			endcase
		end
	end

	// Open-drain data: only ever pulled low, enable high while pulling.
	assign sda_o = 1'b0;
	always_comb begin
		sda_oe_o = 1'b0;
		if (state_r == USCR_ST_ACK) begin
			sda_oe_o = 1'b1;
		end else if (state_r == USCR_ST_SEND) begin
			sda_oe_o = !tx_r[7];
		end
	end

	// ==================================================================
	// Setup and enable registers.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			setup1_r <= USCR_RST_SETUP1;
			setup2_r <= USCR_RST_SETUP2;
			setup3_r <= USCR_RST_SETUP3;
			setup4_r <= USCR_RST_SETUP4;
			irq_en_lower_r <= USCR_RST_ZERO;
			irq_en_upper_r <= USCR_RST_ZERO;
		end else if (STAND_ALONE && !strap_taken_r) begin
			setup1_r <= strap_setup1_i;
			setup4_r <= strap_setup4_i;
		end else begin
			if (adc_i.done) begin
				setup4_r[USCR_S4_CONV_START_BIT] <= 1'b0;
			end
			if (wr_pulse && !STAND_ALONE) begin
				case (ptr_r)
					USCR_IDX_SETUP1: setup1_r <= shift_r;
					USCR_IDX_SETUP2: setup2_r <= shift_r;
					USCR_IDX_SETUP3: setup3_r <= shift_r;
					USCR_IDX_SETUP4: setup4_r <= shift_r;
					default: begin
					end
				endcase
			end
			if (wr_pulse) begin
				case (ptr_r)
					USCR_IDX_IRQ_EN_LOWER: irq_en_lower_r <= shift_r;
					USCR_IDX_IRQ_EN_UPPER: irq_en_upper_r <= shift_r & USCR_MASK_UPPER;
					default: begin
					end
				endcase
			end
		end
	end

	assign output_voltage_mode_o = setup1_r[USCR_S1_VOUT_LSB +: 3];
	assign setup2_o = setup2_r;
	assign setup3_o = setup3_r;
	assign adc_start_o = setup4_r[USCR_S4_CONV_START_BIT];
	assign latch_sel = setup4_r[USCR_S4_LATCH_SEL_BIT];

	// ==================================================================
	// Configured flag gates the converter.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			configured_r <= !SPECIAL_ORDER;
		end else if (wr_pulse && ptr_r == USCR_IDX_LIVE_STATUS) begin
			configured_r <= shift_r[USCR_STAT_CONFIGURED_BIT] | !SPECIAL_ORDER;
		end
	end

	assign dcdc_enable_o = configured_r;

	// ==================================================================
	// Event flags. A new event in the cycle of a clearing read wins.
	assign main_src = {attach_i != attach_prev_r, fault_i};

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			attach_prev_r <= 1'b0;
			event_main_r <= USCR_RST_ZERO;
		end else begin
			attach_prev_r <= attach_i;
			for (int i = 0; i < 8; i++) begin
				if (main_src[i]) begin
					event_main_r[i] <= 1'b1;
				end else if (rd_pulse && rd_idx == USCR_IDX_EVENT_MAIN) begin
					event_main_r[i] <= 1'b0;
				end else if (!latch_sel && i != USCR_EVM_ATTACH_BIT) begin
					event_main_r[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_aux_r <= USCR_RST_ZERO;
			cfg_req_armed_r <= SPECIAL_ORDER;
		end else begin
			cfg_req_armed_r <= 1'b0;
			if (rd_pulse && rd_idx == USCR_IDX_EVENT_AUX) begin
				event_aux_r <= USCR_RST_ZERO;
			end else if (!latch_sel && !input_overvoltage_i) begin
				event_aux_r[USCR_EVA_INPUT_OVERVOLTAGE_FLAG_BIT] <= 1'b0;
			end
			if (input_overvoltage_i) begin
				event_aux_r[USCR_EVA_INPUT_OVERVOLTAGE_FLAG_BIT] <= 1'b1;
			end
			if (adc_i.done) begin
				event_aux_r[USCR_EVA_CONV_DONE_BIT] <= 1'b1;
			end
			if (cfg_req_armed_r && SPECIAL_ORDER) begin
				event_aux_r[USCR_EVA_CFG_REQ_BIT] <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Conversion results.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_voltage_r <= USCR_RST_ZERO;
			bus_current_r <= USCR_RST_ZERO;
		end else if (adc_i.done) begin
			bus_voltage_r <= adc_i.voltage;
			bus_current_r <= adc_i.current;
		end
	end

	// ==================================================================
	// Interrupt output: a level that drops once every enabled flag is read.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_main_r & irq_en_lower_r) ||
				(event_aux_r[USCR_EVA_INPUT_OVERVOLTAGE_FLAG_BIT] && irq_en_upper_r[USCR_UPPER_INPUT_OVERVOLTAGE_FLAG_BIT]) ||
				(event_aux_r[USCR_EVA_CONV_DONE_BIT] && setup4_r[USCR_S4_CONV_IRQ_BIT]);
		end
	end

endmodule // uscr_status_regs
`default_nettype wire

// ### verif/uscr_status_regs_assertions.sv
// Port-level concurrent checks of the charger status register bank.
`timescale 1ns/1ps
`default_nettype none
module uscr_status_regs_checker #(
	parameter bit SPECIAL_ORDER = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire uscr_pkg::uscr_adc_s adc_i,
	input wire logic adc_start_o,
	input wire logic [2:0] output_voltage_mode_o,
	input wire logic [7:0] setup2_o,
	input wire logic [7:0] setup3_o,
	input wire logic dcdc_enable_o,
	input wire logic irq_o
);
	import uscr_pkg::*;
	logic [3:0] high_cnt_r;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ====================
	// A long clock-high run means the bus is idle, so the data pin must be free.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			high_cnt_r <= 4'h0;
		end else if (!scl_i) begin
			high_cnt_r <= 4'h0;
		end else if (high_cnt_r != 4'hf) begin
			high_cnt_r <= high_cnt_r + 4'h1;
		end
	end
	// ====================
	// Checks.
	reset_values_a: assert property ($rose(rst_n_i) |-> !irq_o && !adc_start_o && !sda_oe_o &&
		setup2_o == USCR_RST_SETUP2 && setup3_o == USCR_RST_SETUP3 && output_voltage_mode_o == 3'h0)
		else $error("outputs not at reset values after release");
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	ack_stable_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
		else $error("data pin changed while clock high");
	idle_release_a: assert property (high_cnt_r >= 4'hc |-> !sda_oe_o)
		else $error("data pin held low on idle bus");
	dcdc_standard_a: assert property (!SPECIAL_ORDER |-> dcdc_enable_o)
		else $error("converter held off on standard variant");
	conv_clear_a: assert property (adc_i.done && adc_start_o |-> ##[1:2] !adc_start_o)
		else $error("conversion start not cleared on completion");
	conv_start_src_a: assert property ($rose(adc_start_o) |-> !$past(scl_i, 3))
		else $error("conversion start rose outside a bus write");
	setup_write_src_a: assert property ($changed({setup2_o, setup3_o, output_voltage_mode_o})
		|-> !$past(scl_i, 2))
		else $error("setup output changed outside a bus write");
endmodule // uscr_status_regs_checker

bind uscr_status_regs uscr_status_regs_checker #(.SPECIAL_ORDER(SPECIAL_ORDER)) uscr_status_regs_checker_i (
	.mclk_i, .rst_n_i, .scl_i, .sda_o, .sda_oe_o, .adc_i, .adc_start_o, .output_voltage_mode_o,
	.setup2_o, .setup3_o, .dcdc_enable_o, .irq_o
);
`default_nettype wire

// ### verif/uscr_host_model.sv
// Two-wire bus controller model that drives the register bank's serial pins.
`timescale 1ns/1ps
`default_nettype none
module uscr_host_model (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	logic cur_r = 1'b1;
	logic acks_r;
	initial begin
		scl_o <= 1'b1;
		sda_low_o <= 1'b0;
	end
	// ====================
	// One quarter of a 400 ns bit; the clock idles high between frames.
	task automatic step(input logic c, input logic s);
		scl_o <= c;
		sda_low_o <= !s;
		cur_r = s;
		repeat (2) @(posedge mclk_i);
	endtask
	// Data moves only in the low half, one quarter after the fall, so it never mimics a start or stop.
	task automatic bit_x(input logic b, output logic r);
		step(1'b0, cur_r);
		step(1'b0, b);
		step(1'b1, b);
		r = sda_i;
		step(1'b1, b);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		logic n;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(1'b1, n);
		acks_r = acks_r & !n;
	endtask
	task automatic open_frame();
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic close_frame();
		step(1'b0, cur_r);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// ====================
	// Frames; ok reports whether every byte the device had to take was acknowledged.
	task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		acks_r = 1'b1;
		open_frame();
		xfer({a, 1'b0}, r);
		xfer(i, r);
		xfer(d, r);
		close_frame();
		ok = acks_r;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] i, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		acks_r = 1'b1;
		open_frame();
		xfer({a, 1'b0}, r);
		xfer(i, r);
		step(1'b0, cur_r);
		step(1'b0, 1'b1);
		open_frame();
		xfer({a, 1'b1}, r);
		ok = acks_r;
		xfer(8'hff, d);
		close_frame();
	endtask
endmodule // uscr_host_model
`default_nettype wire

// ### verif/uscr_status_regs_tb_top.sv
// Self-checking bench of the charger status register bank.
`timescale 1ns/1ps
`default_nettype none
module uscr_status_regs_tb_top;
	import uscr_pkg::*;
	logic mclk_i, rst_n_i, scl, sda_low, sda_o, sda_oe, strap, attach, ov, adc_start, dcdc, irq, ok;
	logic [6:0] fault, ta;
	logic [7:0] st1, st4, s2, s3, rd_d, v, c, w1, w2, w3;
	logic [2:0] mode;
	uscr_adc_s adc;
	int miscompares, n_compared;
	wire sda = !(sda_low | sda_oe);
	uscr_status_regs uscr_status_regs_i (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.first_strap_pin_i(strap), .strap_setup1_i(st1), .strap_setup4_i(st4), .attach_i(attach),
		.fault_i(fault), .input_overvoltage_i(ov), .adc_i(adc), .adc_start_o(adc_start),
		.output_voltage_mode_o(mode), .setup2_o(s2), .setup3_o(s3), .dcdc_enable_o(dcdc), .irq_o(irq)
	);
	uscr_host_model uscr_host_model_i (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	// ====================
	// Expectations and compares.
	function automatic logic [7:0] status_f(input logic a);
		return {a, 1'b1, 6'h00};
	endfunction
	function automatic logic [7:0] rst_f(input logic [7:0] i);
		case (i)
			USCR_IDX_SETUP3: return USCR_RST_SETUP3;
			USCR_IDX_SETUP4: return USCR_RST_SETUP4;
			USCR_IDX_LIVE_STATUS: return status_f(1'b0);
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] e);
		uscr_host_model_i.rd(ta, i, rd_d, ok);
		chk1("read ack", 1'b1, ok);
		chk8($sformatf("register %h", i), e, rd_d);
	endtask
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		uscr_host_model_i.wr(ta, i, d, ok);
		chk1("write ack", 1'b1, ok);
	endtask
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ====================
	// Tests.
	initial begin
		void'($urandom(32'h3ebd));
		rst_n_i = 1'b0;
		attach = 1'b0;
		ov = 1'b0;
		fault = '0;
		adc = '0;
		strap = 1'($urandom);
		st1 = 8'($urandom);
		st4 = 8'($urandom);
		ta = {USCR_ADDR_BASE[6:1], strap};
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		for (int i = 0; i < 12; i++) rchk(8'(i), rst_f(8'(i)));
		chk1("converter enable", 1'b1, dcdc);
		$display("test reset done");
		uscr_host_model_i.wr(ta ^ 7'h01, USCR_IDX_IRQ_EN_UPPER, 8'h01, ok);
		chk1("foreign address ack", 1'b0, ok);
		rchk(USCR_IDX_IRQ_EN_UPPER, 8'h00);
		wreg(USCR_IDX_IRQ_EN_UPPER, 8'hff);
		wreg(USCR_IDX_BUS_VOLTAGE, 8'hff);
		wreg(USCR_IDX_EVENT_AUX, 8'hff);
		rchk(USCR_IDX_IRQ_EN_UPPER, USCR_MASK_UPPER);
		rchk(USCR_IDX_BUS_VOLTAGE, 8'h00);
		rchk(USCR_IDX_EVENT_AUX, 8'h00);
		wreg(USCR_IDX_LIVE_STATUS, 8'h00);
		rchk(USCR_IDX_LIVE_STATUS, status_f(1'b0));
		chk1("converter enable after write", 1'b1, dcdc);
		$display("test access done");
		wreg(USCR_IDX_IRQ_EN_LOWER, 8'h80);
		attach <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk1("irq on attach", 1'b1, irq);
		rchk(USCR_IDX_LIVE_STATUS, status_f(1'b1));
		rchk(USCR_IDX_EVENT_MAIN, 8'h80);
		chk1("irq after read", 1'b0, irq);
		rchk(USCR_IDX_EVENT_MAIN, 8'h00);
		wreg(USCR_IDX_IRQ_EN_LOWER, 8'h00);
		attach <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk1("masked detach irq", 1'b0, irq);
		rchk(USCR_IDX_LIVE_STATUS, status_f(1'b0));
		rchk(USCR_IDX_EVENT_MAIN, 8'h80);
		$display("test attach done");
		wreg(USCR_IDX_SETUP4, USCR_RST_SETUP4 | 8'h80);
		for (int k = 0; k < 7; k++) begin
			fault <= 7'h01 << k;
			repeat ($urandom_range(6, 1)) @(posedge mclk_i);
			fault <= '0;
			rchk(USCR_IDX_EVENT_MAIN, 8'h01 << k);
		end
		ov <= 1'b1;
		repeat (3) @(posedge mclk_i);
		ov <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk1("irq on overvoltage", 1'b1, irq);
		rchk(USCR_IDX_EVENT_AUX, 8'h01);
		chk1("irq after aux read", 1'b0, irq);
		wreg(USCR_IDX_SETUP4, USCR_RST_SETUP4);
		fault <= 7'h40;
		repeat (3) @(posedge mclk_i);
		fault <= '0;
		repeat (3) @(posedge mclk_i);
		rchk(USCR_IDX_EVENT_MAIN, 8'h00);
		$display("test events done");
		wreg(USCR_IDX_SETUP4, USCR_RST_SETUP4 | 8'h60);
		repeat (3) @(posedge mclk_i);
		chk1("conversion start", 1'b1, adc_start);
		v = 8'($urandom);
		c = 8'($urandom);
		adc <= {1'b1, v, c};
		@(posedge mclk_i);
		adc.done <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk1("start cleared", 1'b0, adc_start);
		chk1("irq on conversion", 1'b1, irq);
		rchk(USCR_IDX_EVENT_AUX, 8'h02);
		rchk(USCR_IDX_EVENT_AUX, 8'h00);
		rchk(USCR_IDX_BUS_VOLTAGE, v);
		rchk(USCR_IDX_BUS_CURRENT, c);
		rchk(USCR_IDX_SETUP4, USCR_RST_SETUP4 | 8'h20);
		$display("test conversion done");
		w1 = 8'($urandom);
		w2 = 8'($urandom);
		w3 = 8'($urandom);
		wreg(USCR_IDX_SETUP1, w1);
		wreg(USCR_IDX_SETUP2, w2);
		wreg(USCR_IDX_SETUP3, w3);
		chk8("voltage mode output", {5'h00, w1[2:0]}, {5'h00, mode});
		chk8("setup2 output", w2, s2);
		chk8("setup3 output", w3, s3);
		rchk(USCR_IDX_SETUP1, w1);
		// A second reset in mid-run must bring written registers back to their reset values.
		rst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk8("setup2 after reset", USCR_RST_SETUP2, s2);
		chk8("setup3 after reset", USCR_RST_SETUP3, s3);
		rchk(USCR_IDX_SETUP1, USCR_RST_SETUP1);
		rchk(USCR_IDX_BUS_VOLTAGE, 8'h00);
		rchk(USCR_IDX_BUS_CURRENT, 8'h00);
		rchk(USCR_IDX_IRQ_EN_UPPER, 8'h00);
		$display("test setup done");
		test_done();
	end
	// The tests need some 16000 cycles; the 60000-cycle limit, nearly four times that, means a hang.
	initial begin
		repeat (60000) @(posedge mclk_i);
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		test_done();
	end
endmodule // uscr_status_regs_tb_top
`default_nettype wire
